/* File: inc/line_if.sv */
// carries filtered line state from the line monitor to the control logic
`timescale 1ns/1ps
interface line_if;
  import usb_srr_pkg::*;
  line_status_t st;
  modport mon (output st);
  modport ctl (input st);
endinterface

/* File: inc/usb_srr_defines.svh */
// offsets, field positions, reset values and timing counts of the suspend/resume/reset block
`ifndef USB_SRR_DEFINES_SVH
`define USB_SRR_DEFINES_SVH

// register byte offsets
`define OFS_INT_STAT   8'h00
`define OFS_INT_EN     8'h04
`define OFS_ERR_STAT   8'h08
`define OFS_ERR_EN     8'h0c
`define OFS_XFER_STAT  8'h10
`define OFS_CTRL0      8'h14
`define OFS_ADDR       8'h18
`define OFS_EP_EN      8'h1c
`define OFS_FRAME_LO   8'h20
`define OFS_FRAME_HI   8'h24

// interrupt status bits
`define INT_BUS_RESET  0
`define INT_ERROR      1
`define INT_FRAME      2
`define INT_TOKEN      3
`define INT_SLEEP      4
`define INT_RESUME     5
`define INT_STALL      6

// error status bits
`define ERR_PID        0
`define ERR_CRC5       1
`define ERR_CRC16      2

// control-zero bits
`define CTL_PULLUP     0
`define CTL_XCVR       1
`define CTL_LP_EN      2
`define CTL_LP_FLAG    3
`define CTL_REMOTE     4
`define CTL_REGULATOR  5
`define CTL_CLK        6
`define CTL_MOD_RESET  7

// reset values
`define DEF_INT_EN     8'h00
`define DEF_ERR_EN     8'h00
`define DEF_EP_EN      16'h0001
`define DEF_ADDR       7'h00
`define DEF_CTRL0      8'h62

// timing
`define CLK_MHZ        10.0
`define IDLE_SUSPEND_MS 3.0
`define RESUME_K_US    2.5
`define BUS_RESET_US   2.5
`define IDLE_SUSPEND_CYC (int'($ceil(`IDLE_SUSPEND_MS * 1000.0 * `CLK_MHZ)))
`define RESUME_K_CYC   (int'($ceil(`RESUME_K_US * `CLK_MHZ)))
`define BUS_RESET_CYC  (int'($ceil(`BUS_RESET_US * `CLK_MHZ)))

`endif

/* File: inc/usb_srr_pkg.sv */
// types shared by the suspend/resume/reset block
package usb_srr_pkg;

  // power state, one-hot
  typedef enum logic [1:0] {
    PWR_ACTIVE  = 2'b01,
    PWR_SUSPEND = 2'b10
  } pwr_t;

  // decoded, filtered bus line state
  typedef struct packed {
    logic se0;
    logic j;
    logic k;
  } line_status_t;

endpackage

/* File: sim/usb_host_model.sv */
// host-side model that drives the usb data lines and resolves them against the device
`timescale 1ns/1ps
module usb_host_model (
  // bench command: 0 idle J, 1 resume K, 2 single-ended zero
  input  wire logic [1:0] state_i,
  // device drive, enable active low
  input  wire logic       oe_n_i,
  input  wire logic       dp_i,
  input  wire logic       dm_i,
  // resolved pins
  output logic            dp_o,
  output logic            dm_o
);
  // the device wins while it drives; the bench holds K for a whole resume
  always_comb begin
    if (!oe_n_i) begin
      dp_o = dp_i;
      dm_o = dm_i;
    end else begin
      dp_o = (state_i == 2'h0);
      dm_o = (state_i == 2'h1);
    end
  end
endmodule // usb_host_model

/* File: sim/usb_suspend_resume_reset_bench.sv */
// self-checking bench for the suspend, resume and reset block
`timescale 1ns/1ps
`include "usb_srr_defines.svh"
module usb_suspend_resume_reset_bench
  import usb_srr_pkg::*;
;
  // short idle count keeps the run brief
  localparam int IDLE = 100;
  logic        clk_i, rst_i, cyc, stb, we, ack, dp, dm, dpo, dmo, oe_n, pull;
  logic        sof, tok, stall, stop, wake, clken, regen, xcen, susp, irq;
  logic [7:0]  adr, xst, err;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  logic [10:0] fnum;
  logic [6:0]  addr;
  logic [15:0] epen;
  logic [1:0]  lst;
  logic        hung;
  int          n_mismatch, total_checks;

  usb_suspend_resume_reset #(.IDLE_CYCLES(IDLE)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .data_plus_line_i(dp), .data_minus_line_i(dm), .data_plus_line_o(dpo),
    .data_minus_line_o(dmo), .line_oe_n_o(oe_n), .dp_pullup_o(pull),
    .sof_token_i(sof), .frame_num_i(fnum), .token_done_i(tok), .xfer_stat_i(xst),
    .stall_i(stall), .err_event_i(err), .clock_stopped_lowpower_mode_i(stop),
    .lowpower_wake_o(wake), .usb_clk_en_o(clken), .regulator_en_o(regen),
    .xcvr_en_o(xcen), .dev_addr_o(addr), .ep_enable_o(epen), .suspended_o(susp),
    .usb_irq_o(irq));

  usb_host_model i_host (.state_i(lst), .oe_n_i(oe_n), .dp_i(dpo), .dm_i(dmo),
    .dp_o(dp), .dm_o(dm));

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle; ack and read data are taken on a rising edge, a missing ack ends the run
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    q = 32'h0;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (ack === 1'b1)
        break;
    end
    if (ack === 1'b1)
      q = rdat;
    else begin
      n_mismatch++;
      hung = 1'b1;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wait_susp(input logic v, input int n);
    int i;
    for (i = 0; i < n && susp !== v; i++) @(negedge clk_i);
    chk(susp, v);
    if (susp !== v)
      hung = 1'b1;
    // hand back on a rising edge so callers drive stimulus there
    @(posedge clk_i);
  endtask

  task automatic t_defaults();
    rc(`OFS_INT_EN, 32'hff, 32'h0);
    rc(`OFS_ERR_EN, 32'hff, 32'h0);
    rc(`OFS_ADDR, 32'h7f, 32'h0);
    rc(`OFS_EP_EN, 32'hffff, 32'h1);
    rc(`OFS_CTRL0, 32'hff, 32'h62);
    chk({pull, clken, regen, xcen, oe_n, irq}, 32'h1e);
    rc(8'h30, 32'hffffffff, 32'h0);
    $display("test defaults done");
  endtask

  // frame starts spaced well inside the idle count must hold off suspend
  task automatic t_frame();
    int i;
    for (i = 0; i < 6; i++) begin
      tk(30);
      sof <= 1'b1;
      fnum <= 11'h5a3;
      tk(1);
      sof <= 1'b0;
      @(negedge clk_i);
      chk(susp, 1'b0);
    end
    rc(`OFS_FRAME_LO, 32'hff, 32'ha3);
    rc(`OFS_FRAME_HI, 32'h7, 32'h5);
    rc(`OFS_INT_STAT, 32'h4, 32'h4);
    wr(`OFS_INT_STAT, 32'h4);
    rc(`OFS_INT_STAT, 32'h4, 32'h0);
    $display("test frame done");
  endtask

  task automatic t_suspend();
    sof <= 1'b1;
    tk(1);
    sof <= 1'b0;
    tk(IDLE - 10);
    @(negedge clk_i);
    chk(susp, 1'b0);
    wait_susp(1'b1, 30);
    rc(`OFS_INT_STAT, 32'h10, 32'h10);
    $display("test suspend done");
  endtask

  // armed K while clocks are stopped wakes at once, then run-mode resume follows
  task automatic t_lp_resume();
    int i;
    // usb clock bit off, so only the wake path can turn the clock on
    wr(`OFS_CTRL0, 32'h26);
    @(negedge clk_i);
    chk(clken, 1'b0);
    @(posedge clk_i);
    stop <= 1'b1;
    lst <= 2'h1;
    for (i = 0; i < 5 && wake !== 1'b1; i++) @(negedge clk_i);
    chk(wake, 1'b1);
    chk(clken, 1'b1);
    @(posedge clk_i);
    stop <= 1'b0;
    tk(12);
    @(negedge clk_i);
    chk(susp, 1'b1);
    wait_susp(1'b0, 30);
    chk(wake, 1'b0);
    rc(`OFS_INT_STAT, 32'h20, 32'h20);
    rc(`OFS_CTRL0, 32'h8, 32'h8);
    lst <= 2'h0;
    wr(`OFS_CTRL0, 32'h6a);
    rc(`OFS_CTRL0, 32'hff, 32'h62);
    $display("test low-power resume done");
  endtask

  task automatic t_bus_reset();
    wr(`OFS_ADDR, 32'h2a);
    wr(`OFS_EP_EN, 32'h5);
    wr(`OFS_INT_STAT, 32'h1);
    wait_susp(1'b1, 2 * IDLE);
    lst <= 2'h2;
    tk(15);
    lst <= 2'h0;
    rc(`OFS_INT_STAT, 32'h1, 32'h0);
    chk(susp, 1'b1);
    lst <= 2'h2;
    tk(35);
    lst <= 2'h0;
    @(negedge clk_i);
    chk(susp, 1'b0);
    chk(addr, 32'h0);
    chk(epen, 32'h1);
    rc(`OFS_INT_STAT, 32'h1, 32'h1);
    $display("test bus reset done");
  endtask

  task automatic t_remote();
    wr(`OFS_CTRL0, 32'h72);
    @(negedge clk_i);
    chk({oe_n, dpo, dmo, dp, dm}, 32'h5);
    wr(`OFS_CTRL0, 32'h62);
    @(negedge clk_i);
    chk({oe_n, dp, dm}, 32'h6);
    $display("test remote wakeup done");
  endtask

  // error fold is masked twice: per cause and at the main enable
  task automatic t_events();
    wr(`OFS_INT_STAT, 32'hff);
    wr(`OFS_ERR_STAT, 32'hff);
    wr(`OFS_INT_EN, 32'h2);
    err <= 8'h2;
    tok <= 1'b1;
    xst <= 8'h5c;
    stall <= 1'b1;
    tk(1);
    err <= 8'h0;
    tok <= 1'b0;
    stall <= 1'b0;
    rc(`OFS_ERR_STAT, 32'hff, 32'h2);
    rc(`OFS_INT_STAT, 32'h4a, 32'h48);
    chk(irq, 1'b0);
    rc(`OFS_XFER_STAT, 32'hff, 32'h5c);
    wr(`OFS_ERR_EN, 32'h2);
    rc(`OFS_INT_STAT, 32'h2, 32'h2);
    chk(irq, 1'b1);
    wr(`OFS_ERR_STAT, 32'h2);
    rc(`OFS_ERR_STAT, 32'hff, 32'h0);
    chk(irq, 1'b0);
    err <= 8'h1;
    tk(1);
    err <= 8'h0;
    rc(`OFS_ERR_STAT, 32'hff, 32'h1);
    $display("test events done");
  endtask

  task automatic t_modreset();
    wr(`OFS_INT_EN, 32'hff);
    wr(`OFS_ADDR, 32'h11);
    wr(`OFS_CTRL0, 32'he3);
    rc(`OFS_INT_EN, 32'hff, 32'h0);
    rc(`OFS_ERR_EN, 32'hff, 32'h0);
    rc(`OFS_ADDR, 32'h7f, 32'h0);
    rc(`OFS_EP_EN, 32'hffff, 32'h1);
    rc(`OFS_CTRL0, 32'hff, 32'h62);
    $display("test module reset done");
  endtask

  // 100 ns clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // main sequence
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, sof, tok, stall, stop} = 7'h0;
    adr = 8'h0;
    sel = 4'hf;
    wdat = 32'h0;
    fnum = 11'h0;
    xst = 8'h0;
    err = 8'h0;
    lst = 2'h0;
    hung = 1'b0;
    n_mismatch = 0;
    total_checks = 0;
    tk(2);
    rst_i <= 1'b0;
    // a bus cycle or suspend wait that runs out raises hung and cuts the sequence short
    fork
      begin
        t_defaults();
        t_frame();
        t_suspend();
        t_lp_resume();
        t_bus_reset();
        t_remote();
        t_events();
        t_modreset();
      end
      wait (hung === 1'b1);
    join_any
    conclude();
  end
endmodule // usb_suspend_resume_reset_bench

/* File: src/usb_line_monitor.sv */
// synchronises and decodes the data-plus and data-minus pins
`timescale 1ns/1ps
module usb_line_monitor
  import usb_srr_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // raw pins
  input  wire logic data_plus_line_i,
  input  wire logic data_minus_line_i,
  // decoded state
  line_if.mon       lines
);

  typedef struct packed {
    logic [2:0] dp_sync;
    logic [2:0] dm_sync;
    logic       dp;
    logic       dm;
  } mon_state_t;

  mon_state_t s_r;
  mon_state_t s_nxt;

  // stage 0 only feeds stage 1; a level counts once stages 1 and 2 agree
  always_comb begin
    s_nxt = s_r;
    s_nxt.dp_sync = {s_r.dp_sync[1:0], data_plus_line_i};
    s_nxt.dm_sync = {s_r.dm_sync[1:0], data_minus_line_i};
    if (s_r.dp_sync[1] == s_r.dp_sync[2]) begin
      s_nxt.dp = s_r.dp_sync[2];
    end
    if (s_r.dm_sync[1] == s_r.dm_sync[2]) begin
      s_nxt.dm = s_r.dm_sync[2];
    end
  end

  // reset to bus idle (J) so no false reset or resume is seen at start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '{dp_sync: 3'h7, dm_sync: 3'h0, dp: 1'b1, dm: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // full-speed line decode
  assign lines.st.se0 = !s_r.dp && !s_r.dm;
  assign lines.st.j   = s_r.dp && !s_r.dm;
  assign lines.st.k   = !s_r.dp && s_r.dm;

endmodule // usb_line_monitor

/* File: src/usb_suspend_resume_reset.sv */
// suspend, resume, bus reset and interrupt status logic with a wishbone register port
//
// Decided for this implementation: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`include "usb_srr_defines.svh"
module usb_suspend_resume_reset
  import usb_srr_pkg::*;
#(
  parameter int IDLE_CYCLES = `IDLE_SUSPEND_CYC
)(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // usb pins
  input  wire logic        data_plus_line_i,
  input  wire logic        data_minus_line_i,
  output logic             data_plus_line_o,
  output logic             data_minus_line_o,
  output logic             line_oe_n_o,
  output logic             dp_pullup_o,
  // packet engine events
  input  wire logic        sof_token_i,
  input  wire logic [10:0] frame_num_i,
  input  wire logic        token_done_i,
  input  wire logic [7:0]  xfer_stat_i,
  input  wire logic        stall_i,
  input  wire logic [7:0]  err_event_i,
  // power and clock control
  input  wire logic        clock_stopped_lowpower_mode_i,
  output logic             lowpower_wake_o,
  output logic             usb_clk_en_o,
  output logic             regulator_en_o,
  output logic             xcvr_en_o,
  // configuration towards the packet engine
  output logic [6:0]       dev_addr_o,
  output logic [15:0]      ep_enable_o,
  output logic             suspended_o,
  output logic             usb_irq_o
);

  localparam int IW    = $clog2(IDLE_CYCLES + 1);
  localparam int K_CYC = `RESUME_K_CYC;
  localparam int R_CYC = `BUS_RESET_CYC;
  localparam logic [IW-1:0] IDLE_LIM = IW'(IDLE_CYCLES);
  localparam logic [7:0]    K_LIM    = 8'(K_CYC - 1);
  localparam logic [7:0]    R_LIM    = 8'(R_CYC);

  if (IDLE_CYCLES < 2 * R_CYC) begin : g_chk
    $error("IDLE_CYCLES too small to tell idle from bus reset");
  end

  typedef struct packed {
    pwr_t          pwr;
    logic          ack;
    logic [31:0]   rdat;
    logic [7:0]    int_stat;
    logic [7:0]    int_en;
    logic [7:0]    err_stat;
    logic [7:0]    err_en;
    logic [7:0]    xfer_stat;
    logic [7:0]    ctrl;
    logic [6:0]    addr;
    logic [15:0]   ep_en;
    logic [10:0]   frame;
    logic [IW-1:0] idle_cnt;
    logic [7:0]    k_cnt;
    logic [7:0]    se0_cnt;
  } state_t;

  localparam state_t DEFAULTS = '{
    pwr:       PWR_ACTIVE,
    ack:       1'b0,
    rdat:      32'h0000_0000,
    int_stat:  8'h00,
    int_en:    `DEF_INT_EN,
    err_stat:  8'h00,
    err_en:    `DEF_ERR_EN,
    xfer_stat: 8'h00,
    ctrl:      `DEF_CTRL0,
    addr:      `DEF_ADDR,
    ep_en:     `DEF_EP_EN,
    frame:     11'h000,
    idle_cnt:  '0,
    k_cnt:     8'h00,
    se0_cnt:   8'h00
  };

  state_t s_r;
  state_t s_nxt;
  line_if lines ();

  usb_line_monitor u_mon (
    .clk_i             (clk_i),
    .rst_i             (rst_i),
    .data_plus_line_i  (data_plus_line_i),
    .data_minus_line_i (data_minus_line_i),
    .lines             (lines.mon)
  );

  // error bit of main status is a live fold of unmasked error flags
  function automatic logic [7:0] int_view(input state_t s);
    logic [7:0] v;
    v = s.int_stat;
    v[`INT_ERROR] = |(s.err_stat & s.err_en);
    v[7] = 1'b0;
    return v;
  endfunction

  // read decode; unmapped offsets read as zero
  function automatic logic [31:0] rd_word(input state_t s, input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (a)
      `OFS_INT_STAT:  d[7:0]  = int_view(s);
      `OFS_INT_EN:    d[7:0]  = s.int_en;
      `OFS_ERR_STAT:  d[7:0]  = s.err_stat;
      `OFS_ERR_EN:    d[7:0]  = s.err_en;
      `OFS_XFER_STAT: d[7:0]  = s.xfer_stat;
      `OFS_CTRL0:     d[7:0]  = s.ctrl;
      `OFS_ADDR:      d[6:0]  = s.addr;
      `OFS_EP_EN:     d[15:0] = s.ep_en;
      `OFS_FRAME_LO:  d[7:0]  = s.frame[7:0];
      `OFS_FRAME_HI:  d[2:0]  = s.frame[10:8];
      default:        d       = 32'h0000_0000;
    endcase
    return d;
  endfunction

  logic       wr_go;
  logic       mod_rst_wr;
  logic [7:0] wr_b0;
  logic       idle_hit;
  logic       k_hit;
  logic       se0_hit;
  logic       k_seen;

  // a write lands on the edge where the master samples ack high
  assign wr_go      = wb_cyc_i && wb_stb_i && wb_we_i && s_r.ack;
  assign wr_b0      = wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00;
  assign mod_rst_wr = wr_go && (wb_adr_i == `OFS_CTRL0) && wr_b0[`CTL_MOD_RESET];

  // own upstream K is not taken as host resume
  assign k_seen   = lines.st.k && !s_r.ctrl[`CTL_REMOTE];
  assign idle_hit = lines.st.j && !sof_token_i && (s_r.idle_cnt == IDLE_LIM);
  assign k_hit    = k_seen && (s_r.k_cnt == K_LIM);
  assign se0_hit  = lines.st.se0 && (s_r.se0_cnt == R_LIM);

  always_comb begin
    s_nxt = s_r;

    // bus slave: one wait state, ack drops after one cycle
    s_nxt.ack = wb_cyc_i && wb_stb_i && !s_r.ack;
    if (wb_cyc_i && wb_stb_i && !s_r.ack) begin
      s_nxt.rdat = rd_word(s_r, wb_adr_i);
    end

    // idle timer: any non-J state or frame start restarts it
    if (lines.st.j && !sof_token_i) begin
      if (s_r.idle_cnt != IDLE_LIM) begin
        s_nxt.idle_cnt = s_r.idle_cnt + IW'(1);
      end
    end else begin
      s_nxt.idle_cnt = '0;
    end

    // K and SE0 duration counters saturate at 8'hff, well past their limits
    if (k_seen) begin
      if (s_r.k_cnt != 8'hff) begin
        s_nxt.k_cnt = s_r.k_cnt + 8'h01;
      end
    end else begin
      s_nxt.k_cnt = 8'h00;
    end
    if (lines.st.se0) begin
      if (s_r.se0_cnt != 8'hff) begin
        s_nxt.se0_cnt = s_r.se0_cnt + 8'h01;
      end
    end else begin
      s_nxt.se0_cnt = 8'h00;
    end

    // software writes; flags are write-one-to-clear, applied before the sets
    if (wr_go) begin
      unique case (wb_adr_i)
        `OFS_INT_STAT: s_nxt.int_stat = s_r.int_stat & ~wr_b0;
        `OFS_INT_EN:   s_nxt.int_en = wb_sel_i[0] ? wb_dat_i[7:0] : s_r.int_en;
        `OFS_ERR_STAT: s_nxt.err_stat = s_r.err_stat & ~wr_b0;
        `OFS_ERR_EN:   s_nxt.err_en = wb_sel_i[0] ? wb_dat_i[7:0] : s_r.err_en;
        `OFS_CTRL0: begin
          if (wb_sel_i[0]) begin
            s_nxt.ctrl = {1'b0, wr_b0[6:4], s_r.ctrl[`CTL_LP_FLAG] & ~wr_b0[`CTL_LP_FLAG],
                          wr_b0[2:0]};
          end
        end
        `OFS_ADDR:     s_nxt.addr = wb_sel_i[0] ? wb_dat_i[6:0] : s_r.addr;
        `OFS_EP_EN: begin
          if (wb_sel_i[0]) begin
            s_nxt.ep_en[7:0] = wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            s_nxt.ep_en[15:8] = wb_dat_i[15:8];
          end
        end
        default: ;
      endcase
    end

    // packet engine events; sets win over a clear in the same cycle
    if (sof_token_i) begin
      s_nxt.int_stat[`INT_FRAME] = 1'b1;
      s_nxt.frame = frame_num_i;
    end
    if (token_done_i) begin
      s_nxt.int_stat[`INT_TOKEN] = 1'b1;
      s_nxt.xfer_stat = xfer_stat_i;
    end
    if (stall_i) begin
      s_nxt.int_stat[`INT_STALL] = 1'b1;
    end
    s_nxt.err_stat = s_nxt.err_stat | err_event_i;

    // power state machine
    unique case (s_r.pwr)
      PWR_ACTIVE: begin
        if (idle_hit) begin
          s_nxt.pwr = PWR_SUSPEND;
          s_nxt.int_stat[`INT_SLEEP] = 1'b1;
        end
      end
      PWR_SUSPEND: begin
        // any armed K counts; a short glitch is left for firmware to judge
        if (s_r.ctrl[`CTL_LP_EN] && k_seen) begin
          s_nxt.ctrl[`CTL_LP_FLAG] = 1'b1;
        end
        if (k_hit) begin
          s_nxt.int_stat[`INT_RESUME] = 1'b1;
          s_nxt.pwr = PWR_ACTIVE;
        end else if (sof_token_i) begin
          s_nxt.pwr = PWR_ACTIVE;
        end
      end
    endcase

    // bus reset: unconfigured, address zero, out of suspend
    if (se0_hit) begin
      s_nxt.int_stat[`INT_BUS_RESET] = 1'b1;
      s_nxt.addr = `DEF_ADDR;
      s_nxt.ep_en = `DEF_EP_EN;
      s_nxt.pwr = PWR_ACTIVE;
      s_nxt.idle_cnt = '0;
    end

    // module reset bit puts everything back to defaults
    if (mod_rst_wr) begin
      s_nxt = DEFAULTS;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= DEFAULTS;
    end else begin
      s_r <= s_nxt;
    end
  end

  // remote wakeup drives K only while the bit is held and the transceiver is on
  assign line_oe_n_o       = !(s_r.ctrl[`CTL_REMOTE] && s_r.ctrl[`CTL_XCVR]);
  assign data_plus_line_o  = 1'b0;
  assign data_minus_line_o = s_r.ctrl[`CTL_REMOTE];

  // asynchronous wake: raw pins, no clock needed while stopped
  assign lowpower_wake_o = s_r.ctrl[`CTL_LP_EN] && (s_r.pwr == PWR_SUSPEND)
                           && clock_stopped_lowpower_mode_i
                           && !data_plus_line_i && data_minus_line_i;

  assign wb_ack_o       = s_r.ack;
  assign wb_dat_o       = s_r.rdat;
  assign dp_pullup_o    = s_r.ctrl[`CTL_PULLUP];
  assign usb_clk_en_o   = s_r.ctrl[`CTL_CLK] || lowpower_wake_o;
  assign regulator_en_o = s_r.ctrl[`CTL_REGULATOR];
  assign xcvr_en_o      = s_r.ctrl[`CTL_XCVR];
  assign dev_addr_o     = s_r.addr;
  assign ep_enable_o    = s_r.ep_en;
  assign suspended_o    = (s_r.pwr == PWR_SUSPEND);
  assign usb_irq_o      = |(int_view(s_r) & s_r.int_en);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  suspend_entry_a: assert property ($rose(suspended_o) |-> s_r.int_stat[`INT_SLEEP]
    && $past(lines.st.j)) else $error("suspend entered without flag");
  sof_blocks_a: assert property (sof_token_i |=> !$rose(suspended_o))
    else $error("suspend entered during frame traffic");
  lp_resume_a: assert property ((s_r.ctrl[`CTL_LP_EN] && suspended_o && k_seen && !mod_rst_wr)
    |=> s_r.ctrl[`CTL_LP_FLAG]) else $error("low-power resume flag missed");
  async_wake_a: assert property (s_r.ctrl[`CTL_LP_EN] && suspended_o
    && clock_stopped_lowpower_mode_i && !data_plus_line_i && data_minus_line_i
    |-> lowpower_wake_o && usb_clk_en_o) else $error("armed K did not wake clocks");
  resume_time_a: assert property ($rose(s_r.int_stat[`INT_RESUME]) |-> $past(k_seen)
    && $past(s_r.k_cnt) == K_LIM) else $error("resume flag at wrong K time");
  remote_drive_a: assert property (s_r.ctrl[`CTL_REMOTE] && xcvr_en_o |-> !line_oe_n_o
    && !data_plus_line_o && data_minus_line_o) else $error("remote wake K not driven");
  bus_reset_a: assert property ((se0_hit && !mod_rst_wr) |=> dev_addr_o == 7'h00
    && s_r.int_stat[`INT_BUS_RESET] && !suspended_o) else $error("bus reset not applied");
  short_se0_a: assert property ($rose(s_r.int_stat[`INT_BUS_RESET]) |->
    $past(s_r.se0_cnt) == R_LIM) else $error("bus reset before SE0 time");
  error_fold_a: assert property ((|(s_r.err_stat & s_r.err_en)) && s_r.int_en[`INT_ERROR]
    |-> usb_irq_o) else $error("unmasked error not reported");
  frame_cap_a: assert property ((sof_token_i && !mod_rst_wr) |=> s_r.frame == $past(frame_num_i)
    && s_r.int_stat[`INT_FRAME]) else $error("frame number not captured");
  flag_sticky_a: assert property ((s_r.int_stat[`INT_TOKEN] && !wr_go) |=>
    s_r.int_stat[`INT_TOKEN]) else $error("flag dropped without clear");
  mod_reset_a: assert property (mod_rst_wr |=> s_r.int_en == 8'h00 && dev_addr_o == 7'h00
    && ep_enable_o == 16'h0001 && !dp_pullup_o && xcvr_en_o) else $error("module reset incomplete");

  suspend_c: cover property ($rose(suspended_o));
  resume_c: cover property ($rose(s_r.int_stat[`INT_RESUME]));
  bus_reset_c: cover property ($rose(s_r.int_stat[`INT_BUS_RESET]) && $past(suspended_o));
  lp_wake_c: cover property ($rose(s_r.ctrl[`CTL_LP_FLAG]));

endmodule // usb_suspend_resume_reset
